//--- hdl/dmh_defines.svh
// Constants for the DMA master handshake controller
`ifndef DMH_DEFINES_SVH
`define DMH_DEFINES_SVH
`define DMH_NCH 16
`define DMH_NDEV 16
`define DMH_NTERM 12
`define DMH_DEVW 4
`define DMH_AW 16
`define DMH_FIFO_DEPTH 32
`define DMH_SMB_PAIRS 5
`define DMH_GSPI_PAIRS 2
`define DMH_QSPI_TX_DEV 10
`define DMH_QSPI_RX_DEV 11
`define DMH_GSPI_BASE 12
`define DMH_ADDR_STEP 1
`endif

//--- hdl/dmh_pkg.sv
// Types for the DMA master handshake controller
package dmh_pkg;
  typedef enum logic {
    DMH_ARB_IDLE,
    DMH_ARB_HOLD
  } dmh_arb_state_t;
endpackage

//--- hdl/dmh_fifo.sv
// Request FIFO between channel service and memory port
`timescale 1ns/1ps
module dmh_fifo import dmh_pkg::*; #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic empty
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[PW:0]);
  assign out_valid = (count != '0);
  assign empty = (count == '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (srst) count <= DEPTH[PW:0])
    else $error("fifo count above depth");
endmodule // dmh_fifo

//--- hdl/dmh_ctrl.sv
// DMA master handshake, arbitration, reset and sleep control
`timescale 1ns/1ps
`include "dmh_defines.svh"

// Function
// - The controller drives a done line to each bus and quad SPI master when its transfer ends.
// - General SPI masters 12 to 15 have a request line only, with no terminate and no done.
// - Counters and control logic run on the single system clock.
// - System reset returns every register except the FIFO storage array to its default.
// - The block reset is active when system reset or the software reset bit is set.
// - Each channel drives its own interrupt from its transfer-complete flag.
// - A sleep command is acknowledged only once every channel transaction has completed.
// - For firmware pacing, sleep waits until terminal count is reached and go is cleared.
// - For hardware pacing, a transfer ends at terminal count or on the master's terminate.
// - A hardware paced channel uses the request, terminate and done lines of the master its select field names.
// - When the memory address reaches the end address the bus or quad SPI master of a hardware paced channel is told done.
// - A round-robin arbiter grants channels, and a grant holds until the channel completes.
module dmh_ctrl import dmh_pkg::*; #(
  parameter int NCH = `DMH_NCH,
  parameter int AW = `DMH_AW,
  parameter int FIFO_DEPTH = `DMH_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic soft_reset,
  // Block and channel control
  input wire logic controller_enable,
  input wire logic [NCH-1:0] chan_activate,
  input wire logic [NCH-1:0] chan_hw_flow,
  input wire logic [NCH*`DMH_DEVW-1:0] chan_dev_sel,
  input wire logic [NCH-1:0] chan_go_set,
  input wire logic [NCH-1:0] chan_abort,
  input wire logic [NCH-1:0] chan_status_clr,
  input wire logic [NCH*AW-1:0] chan_start_addr,
  input wire logic [NCH*AW-1:0] chan_end_addr,
  // Channel status
  output logic [NCH-1:0] chan_busy,
  output logic [NCH-1:0] chan_go,
  output logic [NCH-1:0] channel_interrupt,
  // Bus target and controller masters
  input wire logic [`DMH_SMB_PAIRS-1:0] smbus_target_dma_request,
  input wire logic [`DMH_SMB_PAIRS-1:0] smbus_target_dma_terminate,
  output logic [`DMH_SMB_PAIRS-1:0] smbus_target_dma_finished,
  input wire logic [`DMH_SMB_PAIRS-1:0] smbus_controller_dma_request,
  input wire logic [`DMH_SMB_PAIRS-1:0] smbus_controller_dma_terminate,
  output logic [`DMH_SMB_PAIRS-1:0] smbus_controller_dma_finished,
  // Quad SPI masters
  input wire logic quad_spi_tx_request,
  input wire logic quad_spi_tx_terminate,
  output logic quad_spi_tx_finished,
  input wire logic quad_spi_rx_request,
  input wire logic quad_spi_rx_terminate,
  output logic quad_spi_rx_finished,
  // General SPI masters
  input wire logic [`DMH_GSPI_PAIRS-1:0] general_spi_tx_request,
  input wire logic [`DMH_GSPI_PAIRS-1:0] general_spi_rx_request,
  // Power clock reset unit
  input wire logic sleep_req,
  output logic sleep_ack,
  // Memory request stream
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [AW-1:0] mem_addr,
  output logic [$clog2(NCH)-1:0] mem_chan
);
  localparam int CW = $clog2(NCH);
  localparam int DW = `DMH_DEVW;

  // ----------------------------------------
  // Reset and device line gathering
  // ----------------------------------------
  logic rst;
  logic [`DMH_NDEV-1:0] dev_req_raw;
  logic [`DMH_NDEV-1:0] dev_term_raw;
  logic [`DMH_NDEV-1:0] dev_assigned;
  logic [`DMH_NDEV-1:0] dev_req;
  logic [`DMH_NDEV-1:0] dev_term;
  logic [`DMH_NTERM-1:0] fin_out;

  assign rst = srst || soft_reset;

  always_comb begin
    dev_req_raw = '0;
    dev_term_raw = '0;
    for (int p = 0; p < `DMH_SMB_PAIRS; p++) begin
      dev_req_raw[2*p] = smbus_target_dma_request[p];
      dev_req_raw[2*p+1] = smbus_controller_dma_request[p];
      dev_term_raw[2*p] = smbus_target_dma_terminate[p];
      dev_term_raw[2*p+1] = smbus_controller_dma_terminate[p];
    end
    dev_req_raw[`DMH_QSPI_TX_DEV] = quad_spi_tx_request;
    dev_req_raw[`DMH_QSPI_RX_DEV] = quad_spi_rx_request;
    dev_term_raw[`DMH_QSPI_TX_DEV] = quad_spi_tx_terminate;
    dev_term_raw[`DMH_QSPI_RX_DEV] = quad_spi_rx_terminate;
    for (int p = 0; p < `DMH_GSPI_PAIRS; p++) begin
      dev_req_raw[`DMH_GSPI_BASE+2*p] = general_spi_tx_request[p];
      dev_req_raw[`DMH_GSPI_BASE+2*p+1] = general_spi_rx_request[p];
    end
  end

  always_comb begin
    dev_assigned = '0;
    for (int c = 0; c < NCH; c++) begin
      if (chan_activate[c] && chan_hw_flow[c]) begin
        dev_assigned[chan_dev_sel[c*DW +: DW]] = 1'b1;
      end
    end
  end

  assign dev_req = dev_req_raw & dev_assigned;
  assign dev_term = dev_term_raw & dev_assigned;

  always_comb begin
    for (int p = 0; p < `DMH_SMB_PAIRS; p++) begin
      smbus_target_dma_finished[p] = fin_out[2*p];
      smbus_controller_dma_finished[p] = fin_out[2*p+1];
    end
    quad_spi_tx_finished = fin_out[`DMH_QSPI_TX_DEV];
    quad_spi_rx_finished = fin_out[`DMH_QSPI_RX_DEV];
  end

  // ----------------------------------------
  // Channel eligibility and arbitration
  // ----------------------------------------
  dmh_arb_state_t arb_state;
  logic [CW-1:0] grant_idx;
  logic [CW-1:0] last_idx;
  logic [CW-1:0] next_idx;
  logic next_found;
  logic [NCH-1:0] chan_req;
  logic [NCH-1:0] chan_eligible;
  logic [AW-1:0] addr [NCH];
  logic [DW-1:0] g_sel;
  logic g_hw;
  logic at_end;
  logic g_term;
  logic complete;
  logic push;
  logic fifo_in_ready;
  logic fifo_empty;
  logic all_idle;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_req[c] = chan_activate[c] && controller_enable &&
                    (chan_hw_flow[c] ? dev_req[chan_dev_sel[c*DW +: DW]] : chan_go[c]);
    end
  end

  assign chan_eligible = chan_req & ~channel_interrupt & {NCH{!sleep_req}};

  always_comb begin
    next_idx = '0;
    next_found = 1'b0;
    for (int k = 1; k <= NCH; k++) begin
      if (!next_found && chan_eligible[CW'((int'(last_idx) + k) % NCH)]) begin
        next_idx = CW'((int'(last_idx) + k) % NCH);
        next_found = 1'b1;
      end
    end
  end

  assign g_sel = chan_dev_sel[grant_idx*DW +: DW];
  assign g_hw = chan_hw_flow[grant_idx];
  assign at_end = (addr[grant_idx] == chan_end_addr[grant_idx*AW +: AW]);
  assign g_term = g_hw && dev_term[g_sel];
  assign complete = (arb_state == DMH_ARB_HOLD) && (at_end || g_term || chan_abort[grant_idx]);
  assign push = (arb_state == DMH_ARB_HOLD) && !complete && chan_req[grant_idx] && fifo_in_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      arb_state <= DMH_ARB_IDLE;
      grant_idx <= '0;
      last_idx <= CW'(NCH - 1);
    end else begin
      case (arb_state)
        DMH_ARB_IDLE: begin
          if (next_found) begin
            arb_state <= DMH_ARB_HOLD;
            grant_idx <= next_idx;
          end
        end
        DMH_ARB_HOLD: begin
          if (complete) begin
            arb_state <= DMH_ARB_IDLE;
            last_idx <= grant_idx;
          end
        end
        default: arb_state <= DMH_ARB_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Per-channel state
  // ----------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_chan
      logic mine;
      assign mine = (arb_state == DMH_ARB_HOLD) && (grant_idx == CW'(gc));

      always_ff @(posedge clk) begin
        if (rst) begin
          addr[gc] <= '0;
        end else if (arb_state == DMH_ARB_IDLE && next_found && next_idx == CW'(gc)) begin
          addr[gc] <= chan_start_addr[gc*AW +: AW];
        end else if (mine && push) begin
          addr[gc] <= addr[gc] + AW'(`DMH_ADDR_STEP);
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          chan_busy[gc] <= 1'b0;
        end else begin
          chan_busy[gc] <= (arb_state == DMH_ARB_IDLE && next_found && next_idx == CW'(gc)) ||
                           (mine && !complete);
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          chan_go[gc] <= 1'b0;
        end else if (chan_go_set[gc] && !chan_hw_flow[gc]) begin
          chan_go[gc] <= 1'b1;
        end else if ((mine && complete) || chan_abort[gc]) begin
          chan_go[gc] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          channel_interrupt[gc] <= 1'b0;
        end else if (mine && complete) begin
          channel_interrupt[gc] <= 1'b1;
        end else if (chan_status_clr[gc]) begin
          channel_interrupt[gc] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Done pulses to masters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fin_out <= '0;
    end else begin
      for (int d = 0; d < `DMH_NTERM; d++) begin
        fin_out[d] <= complete && g_hw && dev_assigned[d] && (g_sel == DW'(d));
      end
    end
  end

  // ----------------------------------------
  // Sleep handshake
  // ----------------------------------------
  assign all_idle = (arb_state == DMH_ARB_IDLE) && (chan_go == '0) && fifo_empty;

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_ack <= 1'b0;
    end else begin
      sleep_ack <= sleep_req && all_idle;
    end
  end

  // ----------------------------------------
  // Memory request FIFO
  // ----------------------------------------
  dmh_fifo #(
    .WIDTH(CW + AW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({grant_idx, addr[grant_idx]}),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data({mem_chan, mem_addr}),
    .empty(fifo_empty)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESET_CLEAR: assert property (disable iff (1'b0) $past(srst) |->
    (channel_interrupt == '0 && !sleep_ack && fin_out == '0 && chan_go == '0))
    else $error("state not cleared by reset");
  AST_SOFT_RESET: assert property (disable iff (1'b0) $past(soft_reset) |->
    (arb_state == DMH_ARB_IDLE && chan_busy == '0))
    else $error("soft reset did not clear block");
  AST_GRANT_HOLD: assert property ((arb_state == DMH_ARB_HOLD && !complete) |=>
    (arb_state == DMH_ARB_HOLD && $stable(grant_idx)))
    else $error("grant dropped before completion");
  AST_END_DONE: assert property ((arb_state == DMH_ARB_HOLD && at_end && g_hw && g_sel < DW'(`DMH_GSPI_BASE)) |=>
    (fin_out != '0) ##1 (fin_out == '0))
    else $error("end address did not give one done pulse");
  AST_TERM_END: assert property ((arb_state == DMH_ARB_HOLD && g_term) |=>
    (arb_state == DMH_ARB_IDLE))
    else $error("terminate did not end transfer");
  AST_GSPI_NODONE: assert property ((complete && g_hw && g_sel >= DW'(`DMH_GSPI_BASE)) |=> (fin_out == '0))
    else $error("done raised for general SPI master");
  AST_IRQ_SET: assert property (complete |=> channel_interrupt[$past(grant_idx)])
    else $error("interrupt flag not set on completion");
  AST_SLEEP_IDLE: assert property (sleep_ack |-> ($past(chan_go) == '0 &&
    $past(arb_state) == DMH_ARB_IDLE))
    else $error("sleep acknowledged with work pending");
  AST_SLEEP_NOGRANT: assert property (sleep_req |=> !$rose(arb_state == DMH_ARB_HOLD))
    else $error("new grant while sleep requested");
  AST_DONE_PULSE: assert property ((fin_out != '0) |=> ((fin_out & $past(fin_out)) == '0))
    else $error("done held longer than one clock");
  AST_IGNORE_UNASSIGNED: assert property ((fin_out != '0) |->
    ((fin_out & ~$past(dev_assigned[`DMH_NTERM-1:0])) == '0))
    else $error("done raised for unassigned master");

  COV_HW_DONE: cover property (complete && g_hw && at_end);
  COV_TERM: cover property (complete && g_term);
  COV_SLEEP: cover property (sleep_req ##[1:20] sleep_ack);
  COV_FIFO_STALL: cover property (arb_state == DMH_ARB_HOLD && chan_req[grant_idx] && !fifo_in_ready);
endmodule // dmh_ctrl

//--- testbench/dmh_master_model.sv
// Model of the peripheral DMA masters driving request and terminate lines
`timescale 1ns/1ps
`include "dmh_defines.svh"
module dmh_master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench commands, one bit per master
  input wire logic [`DMH_NDEV-1:0] raise,
  input wire logic [`DMH_NDEV-1:0] lower,
  input wire logic [`DMH_NTERM-1:0] stop,
  // Bus target and controller masters
  output logic [`DMH_SMB_PAIRS-1:0] st_req,
  output logic [`DMH_SMB_PAIRS-1:0] st_term,
  input wire logic [`DMH_SMB_PAIRS-1:0] st_fin,
  output logic [`DMH_SMB_PAIRS-1:0] sc_req,
  output logic [`DMH_SMB_PAIRS-1:0] sc_term,
  input wire logic [`DMH_SMB_PAIRS-1:0] sc_fin,
  // Quad SPI masters
  output logic qtx_req,
  output logic qtx_term,
  input wire logic qtx_fin,
  output logic qrx_req,
  output logic qrx_term,
  input wire logic qrx_fin,
  // General SPI masters
  output logic [`DMH_GSPI_PAIRS-1:0] gtx_req,
  output logic [`DMH_GSPI_PAIRS-1:0] grx_req
);
  logic [`DMH_NDEV-1:0] req;
  logic [`DMH_NTERM-1:0] term;
  logic [`DMH_NTERM-1:0] fin;
  // Request and terminate held until done or withdrawn
  always_ff @(posedge clk) begin
    if (srst) begin
      req <= '0;
      term <= '0;
    end else begin
      req <= (req | raise) & ~lower & ~{4'h0, fin};
      term <= (term | stop) & ~fin & ~lower[`DMH_NTERM-1:0];
    end
  end
  for (genvar p = 0; p < `DMH_SMB_PAIRS; p++) begin : g_smb
    assign st_req[p] = req[2*p];
    assign sc_req[p] = req[2*p+1];
    assign st_term[p] = term[2*p];
    assign sc_term[p] = term[2*p+1];
    assign fin[2*p] = st_fin[p];
    assign fin[2*p+1] = sc_fin[p];
  end
  assign qtx_req = req[`DMH_QSPI_TX_DEV];
  assign qrx_req = req[`DMH_QSPI_RX_DEV];
  assign qtx_term = term[`DMH_QSPI_TX_DEV];
  assign qrx_term = term[`DMH_QSPI_RX_DEV];
  assign fin[`DMH_QSPI_TX_DEV] = qtx_fin;
  assign fin[`DMH_QSPI_RX_DEV] = qrx_fin;
  for (genvar q = 0; q < `DMH_GSPI_PAIRS; q++) begin : g_gspi
    assign gtx_req[q] = req[`DMH_GSPI_BASE+2*q];
    assign grx_req[q] = req[`DMH_GSPI_BASE+2*q+1];
  end
endmodule // dmh_master_model

//--- testbench/dmh_ctrl_bench.sv
// Testbench for the DMA master handshake controller
`timescale 1ns/1ps
`include "dmh_defines.svh"
module dmh_ctrl_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic soft_reset = 1'b0;
  logic controller_enable = 1'b0;
  logic [15:0] chan_activate = '0;
  logic [15:0] chan_hw_flow = '0;
  logic [63:0] chan_dev_sel = '0;
  logic [15:0] chan_go_set = '0;
  logic [15:0] chan_abort = '0;
  logic [15:0] chan_status_clr = '0;
  logic [255:0] chan_start_addr = '0;
  logic [255:0] chan_end_addr = '0;
  logic [15:0] chan_busy, chan_go, channel_interrupt;
  logic [4:0] st_req, st_term, st_fin, sc_req, sc_term, sc_fin;
  logic qtx_req, qtx_term, qtx_fin, qrx_req, qrx_term, qrx_fin;
  logic [1:0] gtx_req, grx_req;
  logic sleep_req = 1'b0;
  logic sleep_ack, mem_valid;
  logic mem_ready = 1'b0;
  logic [15:0] mem_addr;
  logic [3:0] mem_chan;
  logic [15:0] raise = '0;
  logic [15:0] lower = '0;
  logic [11:0] stop = '0;
  int bad_count = 0;
  int n_compared = 0;
  int pushes = 0;
  int fin_cnt = 0;
  int p0, f0, i;
  logic [15:0] last_addr = '0;
  logic [3:0] last_chan = '0;

  always #5 clk = ~clk;

  dmh_ctrl dut (.clk(clk), .srst(srst), .soft_reset(soft_reset), .controller_enable(controller_enable),
    .chan_activate(chan_activate), .chan_hw_flow(chan_hw_flow), .chan_dev_sel(chan_dev_sel),
    .chan_go_set(chan_go_set), .chan_abort(chan_abort), .chan_status_clr(chan_status_clr),
    .chan_start_addr(chan_start_addr), .chan_end_addr(chan_end_addr), .chan_busy(chan_busy),
    .chan_go(chan_go), .channel_interrupt(channel_interrupt), .smbus_target_dma_request(st_req),
    .smbus_target_dma_terminate(st_term), .smbus_target_dma_finished(st_fin),
    .smbus_controller_dma_request(sc_req), .smbus_controller_dma_terminate(sc_term),
    .smbus_controller_dma_finished(sc_fin), .quad_spi_tx_request(qtx_req), .quad_spi_tx_terminate(qtx_term),
    .quad_spi_tx_finished(qtx_fin), .quad_spi_rx_request(qrx_req), .quad_spi_rx_terminate(qrx_term),
    .quad_spi_rx_finished(qrx_fin), .general_spi_tx_request(gtx_req), .general_spi_rx_request(grx_req),
    .sleep_req(sleep_req), .sleep_ack(sleep_ack), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .mem_chan(mem_chan));

  dmh_master_model masters (.clk(clk), .srst(srst), .raise(raise), .lower(lower), .stop(stop),
    .st_req(st_req), .st_term(st_term), .st_fin(st_fin), .sc_req(sc_req), .sc_term(sc_term),
    .sc_fin(sc_fin), .qtx_req(qtx_req), .qtx_term(qtx_term), .qtx_fin(qtx_fin), .qrx_req(qrx_req),
    .qrx_term(qrx_term), .qrx_fin(qrx_fin), .gtx_req(gtx_req), .grx_req(grx_req));

  // Stream, done pulse and grant monitors
  always @(posedge clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      pushes++;
      last_addr = mem_addr;
      last_chan = mem_chan;
    end
    fin_cnt += $countones({st_fin, sc_fin, qtx_fin, qrx_fin});
    if (!srst && $countones(chan_busy) > 1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, chan_busy, 16'h0001);
    end
  end

  task end_sim;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cfg(input int c, input logic hw, input logic [3:0] dev, input logic [15:0] sa, input logic [15:0] ea);
    chan_hw_flow[c] = hw;
    chan_dev_sel[c*4+:4] = dev;
    chan_start_addr[c*16+:16] = sa;
    chan_end_addr[c*16+:16] = ea;
    chan_activate[c] = 1'b1;
  endtask

  task wait_irq(input int c);
    for (i = 0; i < 400 && channel_interrupt[c] !== 1'b1; i++) tick;
    if (channel_interrupt[c] !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, channel_interrupt[c], 1'b1);
      end_sim;
    end else begin
      tick;
      p0 = pushes - p0;
      f0 = fin_cnt - f0;
    end
  endtask

  task mark;
    p0 = pushes;
    f0 = fin_cnt;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk({chan_busy, channel_interrupt}, 0);
    chk({sleep_ack, mem_valid, chan_go}, 0);
    controller_enable = 1'b1;
    mem_ready = 1'b1;
    // Firmware paced transfer ends at end address
    mark;
    cfg(0, 1'b0, 4'h6, 16'h0010, 16'h0013);
    chan_go_set[0] = 1'b1;
    tick;
    chan_go_set[0] = 1'b0;
    wait_irq(0);
    chk(p0, 3);
    chk(last_addr, 16'h0012);
    chk({chan_go[0], chan_busy[0], f0[0]}, 0);
    // Hardware paced quad SPI transmit
    mark;
    cfg(1, 1'b1, 4'ha, 16'h0020, 16'h0022);
    raise[10] = 1'b1;
    tick;
    raise = '0;
    wait_irq(1);
    chk(p0, 2);
    chk(f0, 1);
    chk(channel_interrupt, 16'h0003);
    // FIFO fills with memory stalled, then master terminates
    mark;
    mem_ready = 1'b0;
    cfg(2, 1'b1, 4'h3, 16'h0000, 16'h0100);
    raise[3] = 1'b1;
    tick;
    raise = '0;
    repeat (60) tick;
    chk(chan_busy, 16'h0004);
    stop[3] = 1'b1;
    tick;
    stop = '0;
    wait_irq(2);
    chk(f0, 1);
    mark;
    mem_ready = 1'b1;
    repeat (40) tick;
    chk(pushes - p0, 32);
    chk(mem_valid, 0);
    chk({last_chan, last_addr}, 20'h2001f);
    // Unassigned master is ignored
    mark;
    raise[5] = 1'b1;
    stop[5] = 1'b1;
    tick;
    raise = '0;
    stop = '0;
    repeat (10) tick;
    chk(chan_busy, 0);
    chk(fin_cnt - f0, 0);
    lower[5] = 1'b1;
    tick;
    lower = '0;
    // General SPI master gets no done line
    mark;
    cfg(3, 1'b1, 4'hc, 16'h0030, 16'h0031);
    raise[12] = 1'b1;
    tick;
    raise = '0;
    wait_irq(3);
    chk(p0, 1);
    chk(f0, 0);
    lower[12] = 1'b1;
    tick;
    lower = '0;
    // Round robin after last granted channel
    mark;
    cfg(4, 1'b0, 4'h7, 16'h0040, 16'h0042);
    cfg(5, 1'b0, 4'h8, 16'h0050, 16'h0052);
    chan_go_set = 16'h0030;
    tick;
    chan_go_set = '0;
    for (i = 0; i < 20 && chan_busy === 16'h0000; i++) tick;
    chk(chan_busy, 16'h0010);
    wait_irq(5);
    chk(channel_interrupt[5:4], 2'h3);
    // Sleep deferred while go is pending
    sleep_req = 1'b1;
    for (i = 0; i < 4 && sleep_ack !== 1'b1; i++) tick;
    chk(sleep_ack, 1);
    cfg(6, 1'b0, 4'h9, 16'h0060, 16'h0061);
    chan_go_set[6] = 1'b1;
    tick;
    chan_go_set = '0;
    repeat (5) tick;
    chk({chan_busy[6], sleep_ack}, 0);
    sleep_req = 1'b0;
    mark;
    wait_irq(6);
    chk(p0, 1);
    // Cleared flag lets a channel rerun, abort ends it
    chan_status_clr[0] = 1'b1;
    tick;
    chan_status_clr = '0;
    chk(channel_interrupt[0], 0);
    chan_go_set[0] = 1'b1;
    tick;
    chan_go_set = '0;
    tick;
    chk(chan_busy[0], 1);
    chan_abort[0] = 1'b1;
    tick;
    chan_abort = '0;
    chk({chan_go[0], chan_busy[0], channel_interrupt[0]}, 1);
    // Software reset clears the block
    soft_reset = 1'b1;
    tick;
    tick;
    soft_reset = 1'b0;
    chk(channel_interrupt, 0);
    chk({chan_go, chan_busy}, 0);
    end_sim;
  end
endmodule // dmh_ctrl_bench
